// [verilog/sps_shifter.sv]
// eight-stage serial-in parallel-out shifter with gated serial entry
// assumes all pins synchronous to clk; shiftClock is sampled and its rising edge detected
module sps_shifter
    import sps_pkg::*;
#(
    parameter int WIDTH = STAGES   // number of stages
)(
    input  wire logic             clk,          // system clock, 250 MHz
    input  wire logic             rst,          // synchronous reset, active high
    input  wire logic             ce,           // clock enable, freezes all state when low
    input  wire logic             serialA,      // serial data input a
    input  wire logic             serialB,      // serial data input b
    input  wire logic             shiftClock,   // shift clock pin, rising edge shifts
    input  wire logic             asyncClear_n, // master clear, active low
    output logic [WIDTH-1:0]      stageOutputs, // parallel stage values
    output sps_mode_t             lastMode      // last action taken
);
    // refuse widths the chain cannot serve
    initial begin
        if (WIDTH < 2) begin
            $error("sps_shifter: WIDTH must be at least 2");
        end
    end

    logic             shiftClockPrev;
    logic [WIDTH-1:0] chain;
    sps_mode_t        next_lastMode;

    // edge detect on the sampled shift clock; a clock pin in the core domain avoids a second domain
    wire shiftEdge = shiftClock & ~shiftClockPrev;
    wire clearNow  = ~asyncClear_n;
    // gate decode, shared by the datapath and the checks below
    function automatic logic sps_entry_ref(input logic a, input logic b);
        begin
            sps_entry_ref = a & b;
        end
    endfunction : sps_entry_ref

    wire entryBit  = sps_entry_ref(serialA, serialB);
    // shift only on an edge with clear released
    wire shiftNow  = shiftEdge & ~clearNow;

    assign next_lastMode = clearNow ? SPS_CLEAR : (shiftNow ? SPS_SHIFT : SPS_IDLE);

    // previous shift clock level for edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            shiftClockPrev <= 1'b0;
        end else if (ce) begin
            shiftClockPrev <= shiftClock;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_stage
            sps_stage u_stage (
                .clk      (clk),
                .rst      (rst),
                .ce       (ce),
                .clearNow (clearNow),
                .shiftNow (shiftNow),
                .dataIn   ((i == FIRST_POS) ? entryBit : chain[(i == 0) ? 0 : i-1]),
                .dataOut  (chain[i])
            );
        end
    endgenerate

    // clear is taken on the next clock; the core has no truly asynchronous path
    assign stageOutputs = chain;

    // status of the last action
    always_ff @(posedge clk) begin
        if (rst) begin
            lastMode <= SPS_IDLE;
        end else if (ce) begin
            lastMode <= next_lastMode;
        end
    end

    // checks below compare the registered outputs one clock after the sampled pins
    // a shift edge needs a low sample first, so with ce high and rst low two edges are never on adjacent clocks
    // everything is frozen while ce is low, the edge detector included
    // the checks are switched off during reset; reset_zero_a watches reset itself

    reset_zero_a: assert property (@(posedge clk)
        rst
        |=> (stageOutputs == '0 && lastMode == SPS_IDLE))
        else $error("reset did not clear the stages");

    entry_bit_a: assert property (@(posedge clk) disable iff (rst)
        (ce && shiftEdge && !clearNow)
        |=> (stageOutputs[0] == $past(entryBit)))
        else $error("first stage did not load the gated serial bit");

    gate_closed_a: assert property (@(posedge clk) disable iff (rst)
        (ce && shiftNow && !(serialA && serialB))
        |=> !stageOutputs[FIRST_POS])
        else $error("first stage loaded high with the gate closed");

    shift_move_a: assert property (@(posedge clk) disable iff (rst)
        (ce && shiftEdge && !clearNow)
        |=> (stageOutputs[WIDTH-1:1] == $past(stageOutputs[WIDTH-2:0])))
        else $error("stages did not move one place");

    // per-stage step, so a single broken link names its own stage
    generate
        for (i = 1; i < WIDTH; i++) begin : g_move_chk
            stage_step_a: assert property (@(posedge clk) disable iff (rst)
                (ce && shiftNow)
                |=> (stageOutputs[i] == $past(stageOutputs[i-1])))
                else $error("a stage missed its neighbour's value");
        end
    endgenerate

    clear_zero_a: assert property (@(posedge clk) disable iff (rst)
        (ce && clearNow)
        |=> (stageOutputs == '0))
        else $error("clear did not zero the stages");

    clear_wins_a: assert property (@(posedge clk) disable iff (rst)
        (ce && clearNow && shiftEdge)
        |=> (stageOutputs == '0 && lastMode == SPS_CLEAR))
        else $error("shift edge won over clear");

    clear_hold_a: assert property (@(posedge clk) disable iff (rst)
        (ce && clearNow)[*2]
        |-> (stageOutputs == '0))
        else $error("stages not zero during held clear");

    hold_value_a: assert property (@(posedge clk) disable iff (rst)
        (!shiftEdge && !clearNow)
        |=> $stable(stageOutputs))
        else $error("stages changed without a shift edge");

    // entry stage quiet between edges, whatever the serial pins do
    entry_quiet_a: assert property (@(posedge clk) disable iff (rst)
        (ce && !shiftNow && !clearNow)
        |=> (stageOutputs[0] == $past(stageOutputs[0])))
        else $error("first stage moved between shift edges");

    freeze_ce_a: assert property (@(posedge clk) disable iff (rst)
        !ce
        |=> $stable(stageOutputs))
        else $error("stages changed while enable low");

    mode_freeze_a: assert property (@(posedge clk) disable iff (rst)
        !ce
        |=> $stable(lastMode))
        else $error("status changed while enable low");

    // full path of a bit over two edges two clocks apart
    bit_walk_a: assert property (@(posedge clk) disable iff (rst)
        (ce && shiftEdge && !clearNow && entryBit) ##1 (ce && !clearNow) ##1 (ce && shiftEdge && !clearNow)
        |=> stageOutputs[1])
        else $error("bit did not reach the second stage");

    mode_clear_a: assert property (@(posedge clk) disable iff (rst)
        (ce && clearNow)
        |=> (lastMode == SPS_CLEAR))
        else $error("mode did not report clear");

    mode_shift_a: assert property (@(posedge clk) disable iff (rst)
        (ce && shiftNow)
        |=> (lastMode == SPS_SHIFT))
        else $error("mode did not report shift");

    mode_idle_a: assert property (@(posedge clk) disable iff (rst)
        (ce && !shiftEdge && !clearNow)
        |=> (lastMode == SPS_IDLE))
        else $error("mode did not report idle");

    // a one entering the chain
    cover_shift_one_c: cover property (@(posedge clk) disable iff (rst)
        ce && shiftEdge && !clearNow && entryBit);

    // a closed gate shifting a zero in
    cover_gate_low_c: cover property (@(posedge clk) disable iff (rst)
        ce && shiftEdge && !clearNow && serialA && !serialB);

    // clear meeting a shift edge
    cover_clear_c: cover property (@(posedge clk) disable iff (rst)
        ce && clearNow && shiftEdge);

    // the shift clock high while frozen
    cover_freeze_c: cover property (@(posedge clk) disable iff (rst)
        !ce && shiftClock);

    // a one reaching the last stage
    cover_walk_c: cover property (@(posedge clk) disable iff (rst)
        stageOutputs[WIDTH-1]);
endmodule : sps_shifter

// [verilog/sps_pkg.sv]
// package for the eight-stage serial-in parallel-out shifter
// assumes a single clock domain; no software-visible registers
package sps_pkg;
    localparam int          STAGES     = 8;          // number of storage stages
    localparam logic [7:0]  CLEAR_VAL  = 8'h00;      // value after clear or reset
    localparam int          FIRST_POS  = 0;          // index of the entry stage
    localparam real         CLK_NS     = 4.0;        // clock period in ns
    // mode encoding of the shifter's last action, shown on a status port
    typedef enum logic [1:0] {
        SPS_IDLE  = 2'b00,
        SPS_SHIFT = 2'b01,
        SPS_CLEAR = 2'b10
    } sps_mode_t;
endpackage : sps_pkg

// [verilog/sps_stage.sv]
// one storage stage of the shifter chain
// assumes clear and shift strobes already qualified by the parent
module sps_stage
    import sps_pkg::*;
(
    input  wire logic clk,        // system clock
    input  wire logic rst,        // synchronous reset, active high
    input  wire logic ce,         // clock enable, freezes state when low
    input  wire logic clearNow,   // clear strobe, overrides shift
    input  wire logic shiftNow,   // shift strobe
    input  wire logic dataIn,     // value from the lower neighbour
    output logic      dataOut     // stage value
);
    logic next_dataOut;

    // clear wins over shift; otherwise hold
    assign next_dataOut = clearNow ? CLEAR_VAL[0] : (shiftNow ? dataIn : dataOut);

    // stage flip-flop
    always_ff @(posedge clk) begin
        if (rst) begin
            dataOut <= CLEAR_VAL[0];
        end else if (ce) begin
            dataOut <= next_dataOut;
        end
    end
endmodule : sps_stage

// [tb/sps_feeder.sv]
// upstream model driving the two serial data inputs
// assumes the bench changes its inputs just after a clk edge
module sps_feeder (
    input  wire logic dataBit, // bit offered for entry
    input  wire logic useGate, // high when b serves as a gate
    input  wire logic gateVal, // gate level while in use
    output logic      serialA, // to serial input a
    output logic      serialB  // to serial input b
);
    timeunit 1ns;
    timeprecision 1ps;
    // gate admits data, unused input tied high
    assign serialA = dataBit;
    assign serialB = useGate ? gateVal : 1'h1;
endmodule : sps_feeder

// [tb/sps_shifter_test.sv]
// self-checking bench for the shifter
// assumes the feeder model stands upstream of the serial inputs
`define CHK(n, e, s) begin samplesChecked++; if ((s) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module sps_shifter_test
    import sps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] WALK_PAT = 8'ha5;
    logic clk = 1'h0, rst = 1'h1, ce = 1'h1, shiftClock = 1'h0, asyncClear_n = 1'h1;
    logic dataBit = 1'h0, useGate = 1'h0, gateVal = 1'h0, serialA, serialB;
    logic [7:0] stageOutputs, expVal = 8'h00;
    sps_mode_t lastMode;
    int errors = 0, samplesChecked = 0, cyc = 0;
    always #2 clk = ~clk;
    sps_feeder i_sps_feeder (.dataBit(dataBit), .useGate(useGate), .gateVal(gateVal),
        .serialA(serialA), .serialB(serialB));
    sps_shifter i_sps_shifter (.clk(clk), .rst(rst), .ce(ce), .serialA(serialA), .serialB(serialB),
        .shiftClock(shiftClock), .asyncClear_n(asyncClear_n), .stageOutputs(stageOutputs),
        .lastMode(lastMode));
    task give_verdict;
        $display("checks %0d mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // one shift edge: low sample already seen, so high counts as an edge
    task shift_one(input logic b, input logic g);
        @(posedge clk);
        dataBit <= b;
        gateVal <= g;
        shiftClock <= 1'h1;
        @(posedge clk);
        shiftClock <= 1'h0;
        #1;
        expVal = {expVal[6:0], b & (useGate ? g : 1'h1)};
        `CHK("stages", expVal, stageOutputs)
        `CHK("mode", SPS_SHIFT, lastMode)
    endtask : shift_one
    task test_walk;
        for (int i = 8; i >= 0; i--) shift_one(WALK_PAT[i % 8], 1'h0);
        $display("walk done");
    endtask : test_walk
    task test_gate;
        useGate <= 1'h1;
        for (int i = 0; i < 4; i++) shift_one(i[1], i[0]);
        useGate <= 1'h0;
        $display("gate done");
    endtask : test_gate
    // data toggling without an edge must leave the stages alone
    task test_hold;
        repeat (5) @(posedge clk) dataBit <= ~dataBit;
        #1;
        `CHK("hold", expVal, stageOutputs)
        `CHK("idlemode", SPS_IDLE, lastMode)
        $display("hold done");
    endtask : test_hold
    // a shift edge while ce is low must not move anything
    task test_freeze;
        @(posedge clk);
        ce <= 1'h0;
        dataBit <= 1'h1;
        shiftClock <= 1'h1;
        @(posedge clk);
        shiftClock <= 1'h0;
        @(posedge clk);
        #1;
        `CHK("freeze", expVal, stageOutputs)
        @(posedge clk);
        ce <= 1'h1;
        $display("freeze done");
    endtask : test_freeze
    // clear raised together with a shift edge: clear must win
    task test_clear;
        @(posedge clk);
        asyncClear_n <= 1'h0;
        shiftClock <= 1'h1;
        @(posedge clk);
        #1;
        `CHK("clear", 8'h00, stageOutputs)
        `CHK("clrmode", SPS_CLEAR, lastMode)
        @(posedge clk);
        asyncClear_n <= 1'h1;
        shiftClock <= 1'h0;
        expVal = 8'h00;
        $display("clear done");
    endtask : test_clear
    // ceiling well above the roughly 45 cycles the tests take
    always @(posedge clk) begin
        cyc++;
        if (cyc == 500) begin
            errors++;
            give_verdict;
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        #1;
        `CHK("reset", 8'h00, stageOutputs)
        test_walk;
        test_gate;
        test_hold;
        test_freeze;
        test_clear;
        shift_one(1'h1, 1'h0);
        give_verdict;
    end
endmodule : sps_shifter_test
